// ---- include/psram_pkg.sv ----
package psram_pkg;

    // ------------------------------------------------------------------
    // Command/address layout
    // ------------------------------------------------------------------
    localparam int CA_BYTES = 6;
    localparam int CA_W = 48;
    localparam int CA_RW_BIT = 47;
    localparam int CA_SPACE_BIT = 46;
    localparam int CA_BURST_BIT = 45;
    localparam int CA_ROW_HI = 44;
    localparam int CA_ROW_LO = 16;
    localparam int CA_COL_HI = 2;
    localparam int ADDR_W = 32;
    localparam int DIE_AW = 24;

    // ------------------------------------------------------------------
    // Wrapped group sizes, as word masks
    // ------------------------------------------------------------------
    localparam logic [1:0] WRAP_SEL_8 = 2'h0;
    localparam logic [1:0] WRAP_SEL_16 = 2'h1;
    localparam logic [1:0] WRAP_SEL_32 = 2'h2;
    localparam logic [31:0] WRAP_MASK_8 = 32'h0000_0007;
    localparam logic [31:0] WRAP_MASK_16 = 32'h0000_000f;
    localparam logic [31:0] WRAP_MASK_32 = 32'h0000_001f;
    localparam logic [31:0] WRAP_MASK_64 = 32'h0000_003f;

    // ------------------------------------------------------------------
    // Counters and reset values
    // ------------------------------------------------------------------
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] DQ_IDLE = 8'h00;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ck;
        logic cs_n;
        logic rst_n;
        logic read_write_strobe;
        logic [7:0] dq;
    } pin_sample_type;

    localparam pin_sample_type PIN_IDLE = '{ck: 1'b0, cs_n: 1'b1, rst_n: 1'b1,
                                            read_write_strobe: 1'b0, dq: 8'h00};

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_LAT,
        ST_READ,
        ST_WRITE
    } bus_state_type;

endpackage

// ---- rtl/pin_sync.sv ----
`timescale 1ns/100ps

// Two-stage synchroniser; the first stage feeds only the second.
module pin_sync #(
    parameter int WIDTH = 12,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            meta_ff <= RESET_VAL;
            sync_ff <= RESET_VAL;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule // pin_sync

// ---- rtl/ddr_psram_bus_slave.sv ----
`timescale 1ns/100ps

// Contract
// R1: Chip select falling opens a transaction; rising ends it at once.
// R2: Host gives each memory its own chip select.
// R3: Clock may be single-ended or differential and may stop between frames.
// R4: During command bytes the strobe is driven; high means extra latency.
// R5: Reset pin low reinitialises to standby and floats data and strobe.
// R6: Each clock cycle moves one 16-bit word as two bytes, one per edge.
// R7: Host centres command bytes between clock edges.
// R8: Order is select, six command bytes, latency, then data until deselect.
// R9: Row and burst type from first two cycles, start word from third.
// R10: Base latency follows commands; refresh adds more, as the strobe showed.
// R11: After the first word each cycle moves the next word of the burst.
// R12: Linear bursts cross row boundaries without pausing.
// R13: Linear bursts past the die's top address restart at its lowest.
// R14: Read data is edge aligned with a strobe driven by the device.
// R15: During writes a high strobe masks the byte, low stores it.
// R16: Host centres write bytes between clock edges.
// R17: Wrapped bursts run to the group end, wrap, and return to the start.
// R18: Linear bursts advance sequentially until chip select rises.
// R19: Each command picks its own burst type.
// R20: Host lowers chip select only with the clock idle low.
// R21: Bit 47 high reads, low writes; bit 46 picks memory or register space.
// R22: Bit 45 low is wrapped, high is linear.
// R23: Bits 44..16 give row and upper column; bits 2..0 the start word.
module ddr_psram_bus_slave #(
    parameter int LATENCY_CYCLES = 6,
    parameter int MEM_AW = 10
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic clock_in,
    input wire logic clock_complement_in,
    input wire logic chip_select_n_in,
    input wire logic reset_n_in,
    input wire logic [7:0] dq_in,
    input wire logic read_write_strobe_in,
    input wire logic refresh_pending_in,
    input wire logic [1:0] wrap_group_sel_in,
    output logic [7:0] dq_out,
    output logic dq_oe_n_out,
    output logic read_write_strobe_out,
    output logic read_write_strobe_oe_n_out,
    output logic busy_out
);
    localparam logic [psram_pkg::CNT_W-1:0] LAT_EDGES =
        psram_pkg::CNT_W'(2 * LATENCY_CYCLES);
    localparam logic [psram_pkg::CNT_W-1:0] CA_LAST =
        psram_pkg::CNT_W'(psram_pkg::CA_BYTES - 1);

    // ------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------
    psram_pkg::pin_sample_type pins_raw;
    psram_pkg::pin_sample_type pins;
    psram_pkg::pin_sample_type prev_ff;
    logic link_edge;
    logic active;
    logic cs_fall;

    // The complement clock is not needed: the true clock alone gives every edge.
    assign pins_raw = '{ck: clock_in, cs_n: chip_select_n_in, rst_n: reset_n_in,
                        read_write_strobe: read_write_strobe_in, dq: dq_in};

    pin_sync #(
        .WIDTH($bits(psram_pkg::pin_sample_type)),
        .RESET_VAL(psram_pkg::PIN_IDLE)
    ) u_pin_sync (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            prev_ff <= psram_pkg::PIN_IDLE;
        end else begin
            prev_ff <= pins;
        end
    end

    // Both edges of the link clock carry a byte, so any change is an edge.
    assign link_edge = pins.ck != prev_ff.ck; // [R6] [R3]
    assign active = pins.rst_n && !pins.cs_n;
    assign cs_fall = prev_ff.cs_n && !pins.cs_n; // [R1]

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0] mem [0:(1 << MEM_AW)-1];
    logic mem_we;
    logic [15:0] mem_wdata;
    logic [1:0] mem_keep;
    logic [15:0] rd_word;

    // ------------------------------------------------------------------
    // Transaction state
    // ------------------------------------------------------------------
    psram_pkg::bus_state_type state_ff, nxt_state_ff;
    logic [psram_pkg::CA_W-1:0] ca_ff, nxt_ca_ff;
    logic [psram_pkg::CNT_W-1:0] cnt_ff, nxt_cnt_ff;
    logic [psram_pkg::CNT_W-1:0] lat_ff, nxt_lat_ff;
    logic [psram_pkg::ADDR_W-1:0] addr_ff, nxt_addr_ff;
    logic refresh_ff, nxt_refresh_ff;
    logic is_read_ff, nxt_is_read_ff;
    logic reg_space_ff, nxt_reg_space_ff;
    logic linear_ff, nxt_linear_ff;
    logic phase_ff, nxt_phase_ff;
    logic [7:0] hi_byte_ff, nxt_hi_byte_ff;
    logic hi_mask_ff, nxt_hi_mask_ff;
    logic [7:0] dq_ff, nxt_dq_ff;
    logic dq_oe_n_ff, nxt_dq_oe_n_ff;
    logic read_write_strobe_ff, nxt_read_write_strobe_ff;
    logic read_write_strobe_oe_n_ff, nxt_read_write_strobe_oe_n_ff;
    logic busy_ff, nxt_busy_ff;
    logic [psram_pkg::ADDR_W-1:0] wrap_mask;
    logic [psram_pkg::ADDR_W-1:0] addr_next;
    logic [psram_pkg::ADDR_W-1:0] addr_inc;
    logic [psram_pkg::CA_W-1:0] ca_shift;

    assign rd_word = reg_space_ff ? psram_pkg::WORD_ZERO : mem[addr_ff[MEM_AW-1:0]];
    assign ca_shift = {ca_ff[psram_pkg::CA_W-9:0], pins.dq};
    assign addr_inc = addr_ff + 32'h0000_0001;

    always_comb begin
        unique case (wrap_group_sel_in)
            psram_pkg::WRAP_SEL_8: wrap_mask = psram_pkg::WRAP_MASK_8;
            psram_pkg::WRAP_SEL_16: wrap_mask = psram_pkg::WRAP_MASK_16;
            psram_pkg::WRAP_SEL_32: wrap_mask = psram_pkg::WRAP_MASK_32;
            default: wrap_mask = psram_pkg::WRAP_MASK_64;
        endcase
    end

    // Linear steps stay inside the die; wrapped steps stay inside the group.
    always_comb begin
        if (linear_ff) begin
            addr_next = {addr_ff[psram_pkg::ADDR_W-1:psram_pkg::DIE_AW],
                         addr_inc[psram_pkg::DIE_AW-1:0]}; // [R18] [R13] [R12]
        end else begin
            addr_next = (addr_ff & ~wrap_mask) | (addr_inc & wrap_mask); // [R17]
        end
    end

    always_comb begin
        nxt_state_ff = state_ff;
        nxt_ca_ff = ca_ff;
        nxt_cnt_ff = cnt_ff;
        nxt_lat_ff = lat_ff;
        nxt_addr_ff = addr_ff;
        nxt_refresh_ff = refresh_ff;
        nxt_is_read_ff = is_read_ff;
        nxt_reg_space_ff = reg_space_ff;
        nxt_linear_ff = linear_ff;
        nxt_phase_ff = phase_ff;
        nxt_hi_byte_ff = hi_byte_ff;
        nxt_hi_mask_ff = hi_mask_ff;
        nxt_dq_ff = dq_ff;
        nxt_dq_oe_n_ff = dq_oe_n_ff;
        nxt_read_write_strobe_ff = read_write_strobe_ff;
        nxt_read_write_strobe_oe_n_ff = read_write_strobe_oe_n_ff;
        mem_we = 1'b0;
        mem_wdata = {hi_byte_ff, pins.dq};
        mem_keep = {hi_mask_ff, pins.read_write_strobe};
        if (!active) begin
            // Reset pin or deselect: back to standby with both lines floated.
            nxt_state_ff = psram_pkg::ST_IDLE; // [R5] [R1]
            nxt_dq_oe_n_ff = 1'b1;
            nxt_read_write_strobe_oe_n_ff = 1'b1;
            nxt_dq_ff = psram_pkg::DQ_IDLE;
            nxt_read_write_strobe_ff = 1'b0;
        end else begin
            unique case (state_ff)
                psram_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        nxt_state_ff = psram_pkg::ST_CMD; // [R8]
                        nxt_cnt_ff = psram_pkg::CNT_ZERO;
                        nxt_refresh_ff = refresh_pending_in;
                        nxt_read_write_strobe_ff = refresh_pending_in; // [R4]
                        nxt_read_write_strobe_oe_n_ff = 1'b0;
                    end
                end
                psram_pkg::ST_CMD: begin
                    if (link_edge) begin
                        nxt_ca_ff = ca_shift;
                        nxt_cnt_ff = cnt_ff + psram_pkg::CNT_ONE;
                        if (cnt_ff == CA_LAST) begin
                            nxt_state_ff = psram_pkg::ST_LAT; // [R8]
                            nxt_cnt_ff = psram_pkg::CNT_ZERO;
                            nxt_is_read_ff = ca_shift[psram_pkg::CA_RW_BIT]; // [R21]
                            nxt_reg_space_ff = ca_shift[psram_pkg::CA_SPACE_BIT];
                            nxt_linear_ff = ca_shift[psram_pkg::CA_BURST_BIT]; // [R22] [R19]
                            nxt_addr_ff = {ca_shift[psram_pkg::CA_ROW_HI:psram_pkg::CA_ROW_LO],
                                           ca_shift[psram_pkg::CA_COL_HI:0]}; // [R9] [R23]
                            nxt_lat_ff = refresh_ff ? LAT_EDGES + LAT_EDGES
                                                    : LAT_EDGES; // [R10]
                            // A read keeps the strobe low until data; a write hands it over.
                            nxt_read_write_strobe_ff = 1'b0;
                            nxt_read_write_strobe_oe_n_ff = !ca_shift[psram_pkg::CA_RW_BIT];
                        end
                    end
                end
                psram_pkg::ST_LAT: begin
                    if (link_edge) begin
                        nxt_cnt_ff = cnt_ff + psram_pkg::CNT_ONE;
                        if (cnt_ff == lat_ff - psram_pkg::CNT_ONE) begin
                            nxt_state_ff = is_read_ff ? psram_pkg::ST_READ
                                                      : psram_pkg::ST_WRITE; // [R10]
                            nxt_phase_ff = 1'b0;
                        end
                    end
                end
                psram_pkg::ST_READ: begin
                    nxt_dq_oe_n_ff = 1'b0;
                    if (link_edge) begin
                        nxt_phase_ff = !phase_ff; // [R6]
                        nxt_read_write_strobe_ff = !phase_ff; // [R14]
                        if (!phase_ff) begin
                            nxt_dq_ff = rd_word[15:8];
                        end else begin
                            nxt_dq_ff = rd_word[7:0];
                            nxt_addr_ff = addr_next; // [R11]
                        end
                    end
                end
                psram_pkg::ST_WRITE: begin
                    if (link_edge) begin
                        nxt_phase_ff = !phase_ff; // [R6]
                        if (!phase_ff) begin
                            nxt_hi_byte_ff = pins.dq;
                            nxt_hi_mask_ff = pins.read_write_strobe;
                        end else begin
                            mem_we = !reg_space_ff; // [R15]
                            nxt_addr_ff = addr_next; // [R11]
                        end
                    end
                end
                default: begin
                    nxt_state_ff = psram_pkg::ST_IDLE;
                end
            endcase
        end
        nxt_busy_ff = nxt_state_ff != psram_pkg::ST_IDLE;
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_ff <= psram_pkg::ST_IDLE;
            ca_ff <= '0;
            cnt_ff <= psram_pkg::CNT_ZERO;
            lat_ff <= psram_pkg::CNT_ZERO;
            addr_ff <= '0;
            refresh_ff <= 1'b0;
            is_read_ff <= 1'b0;
            reg_space_ff <= 1'b0;
            linear_ff <= 1'b0;
            phase_ff <= 1'b0;
            hi_byte_ff <= psram_pkg::DQ_IDLE;
            hi_mask_ff <= 1'b1;
            dq_ff <= psram_pkg::DQ_IDLE;
            dq_oe_n_ff <= 1'b1;
            read_write_strobe_ff <= 1'b0;
            read_write_strobe_oe_n_ff <= 1'b1;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state_ff;
            ca_ff <= nxt_ca_ff;
            cnt_ff <= nxt_cnt_ff;
            lat_ff <= nxt_lat_ff;
            addr_ff <= nxt_addr_ff;
            refresh_ff <= nxt_refresh_ff;
            is_read_ff <= nxt_is_read_ff;
            reg_space_ff <= nxt_reg_space_ff;
            linear_ff <= nxt_linear_ff;
            phase_ff <= nxt_phase_ff;
            hi_byte_ff <= nxt_hi_byte_ff;
            hi_mask_ff <= nxt_hi_mask_ff;
            dq_ff <= nxt_dq_ff;
            dq_oe_n_ff <= nxt_dq_oe_n_ff;
            read_write_strobe_ff <= nxt_read_write_strobe_ff;
            read_write_strobe_oe_n_ff <= nxt_read_write_strobe_oe_n_ff;
            busy_ff <= nxt_busy_ff;
        end
    end

    // A high strobe bit keeps the stored byte.
    always_ff @(posedge ref_clk_in) begin
        if (mem_we) begin
            if (!mem_keep[1]) begin
                mem[addr_ff[MEM_AW-1:0]][15:8] <= mem_wdata[15:8]; // [R15]
            end
            if (!mem_keep[0]) begin
                mem[addr_ff[MEM_AW-1:0]][7:0] <= mem_wdata[7:0]; // [R15]
            end
        end
    end

    assign dq_out = dq_ff;
    assign dq_oe_n_out = dq_oe_n_ff;
    assign read_write_strobe_out = read_write_strobe_ff;
    assign read_write_strobe_oe_n_out = read_write_strobe_oe_n_ff;
    assign busy_out = busy_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_last_ca;
        active && state_ff == psram_pkg::ST_CMD && link_edge && cnt_ff == CA_LAST;
    endsequence

    sequence s_last_lat;
        active && state_ff == psram_pkg::ST_LAT && link_edge
            && cnt_ff == lat_ff - psram_pkg::CNT_ONE;
    endsequence

    sequence s_data_low_edge;
        active && phase_ff && link_edge
            && (state_ff == psram_pkg::ST_READ || state_ff == psram_pkg::ST_WRITE);
    endsequence

    AST_CS_ENDS: assert property (pins.cs_n |=> state_ff == psram_pkg::ST_IDLE // [R1]
        && dq_oe_n_out && read_write_strobe_oe_n_out)
        else $error("Chip select high did not end the transaction.");

    AST_RESET_FLOATS: assert property (!pins.rst_n [*2] |-> dq_oe_n_out // [R5]
        && read_write_strobe_oe_n_out && state_ff == psram_pkg::ST_IDLE)
        else $error("Reset pin low left a line driven.");

    AST_CA_STROBE: assert property (state_ff == psram_pkg::ST_CMD |-> // [R4]
        !read_write_strobe_oe_n_out && read_write_strobe_out == refresh_ff)
        else $error("Strobe did not show latency during command bytes.");

    AST_SIX_BYTES: assert property (s_last_ca |=> state_ff == psram_pkg::ST_LAT // [R8]
        && cnt_ff == psram_pkg::CNT_ZERO)
        else $error("Command phase did not end after six bytes.");

    AST_LATENCY_LEN: assert property ($rose(state_ff == psram_pkg::ST_LAT) |-> // [R10]
        lat_ff == (refresh_ff ? LAT_EDGES + LAT_EDGES : LAT_EDGES))
        else $error("Initial latency length is wrong.");

    AST_DATA_START: assert property (s_last_lat |=> (state_ff == psram_pkg::ST_READ) // [R8]
        == is_read_ff && !phase_ff)
        else $error("Data phase did not follow latency.");

    AST_READ_STROBE: assert property (active && state_ff == psram_pkg::ST_READ // [R14]
        && link_edge |=> read_write_strobe_out == !$past(phase_ff) && !dq_oe_n_out)
        else $error("Read strobe not aligned with data byte.");

    AST_LINEAR_STEP: assert property (s_data_low_edge ##0 linear_ff |=> // [R18]
        addr_ff[psram_pkg::DIE_AW-1:0] == $past(addr_ff[psram_pkg::DIE_AW-1:0]) + 24'h00_0001
        && $stable(addr_ff[psram_pkg::ADDR_W-1:psram_pkg::DIE_AW])) // [R13]
        else $error("Linear burst did not advance inside the die.");

    AST_WRAP_GROUP: assert property (s_data_low_edge ##0 !linear_ff |=> // [R17]
        (addr_ff & ~wrap_mask) == ($past(addr_ff) & ~wrap_mask))
        else $error("Wrapped burst left its group.");

    AST_WRITE_PAIR: assert property (mem_we |-> state_ff == psram_pkg::ST_WRITE // [R6]
        && phase_ff && link_edge && !reg_space_ff)
        else $error("Word written outside the second byte of a write.");

endmodule // ddr_psram_bus_slave

// ---- tb/psram_host_model.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Host controller side of the link.
// ----------------------------------------------------------------
module psram_host_model (
    input wire logic ref_clk_in,
    output logic clock_out,
    output logic chip_select_n_out,
    output logic [7:0] dq_out,
    output logic strobe_out
);
    int half = 4;

    initial begin
        clock_out = 1'b0;
        chip_select_n_out = 1'b1;
        dq_out = 8'h5a;
        strobe_out = 1'b1;
    end

    task automatic wait_ref(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask

    // Mode 0 releases both lines, 1 drives bytes only, 2 drives bytes and mask.
    // Released lines change every edge so stale values are never read back.
    task automatic edge_byte(input logic [7:0] b, input logic m, input logic [1:0] mode);
        dq_out = (mode == 2'h0) ? ~dq_out : b;
        strobe_out = (mode == 2'h2) ? m : ~strobe_out;
        if (mode != 2'h0) begin
            wait_ref(half / 2);
        end
        clock_out = ~clock_out;
        wait_ref((mode == 2'h0) ? half : half / 2);
    endtask

    // The clock stays low while no frame is open.
    task automatic select();
        clock_out = 1'b0;
        chip_select_n_out = 1'b0;
        wait_ref(half);
    endtask

    task automatic deselect();
        wait_ref(half);
        chip_select_n_out = 1'b1;
        wait_ref(2 * half);
    endtask
endmodule // psram_host_model

// ---- tb/ddr_psram_bus_slave_tb_top.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Bench top.
// ----------------------------------------------------------------
module ddr_psram_bus_slave_tb_top;
    localparam int LAT = 3;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic reset_n_in = 1'b1;
    logic refresh_pending_in = 1'b0;
    logic [1:0] wrap_group_sel_in = 2'h0;
    logic host_ck, host_cs_n, host_strobe;
    logic [7:0] host_dq, dq_out;
    logic dq_oe_n_out, read_write_strobe_out, read_write_strobe_oe_n_out, busy_out;
    logic [15:0] shadow [0:1023];
    int miscompares = 0;
    int check_count = 0;

    initial begin
        forever #25 ref_clk_in = ~ref_clk_in;
    end

    psram_host_model host (.ref_clk_in(ref_clk_in), .clock_out(host_ck),
        .chip_select_n_out(host_cs_n), .dq_out(host_dq), .strobe_out(host_strobe));

    ddr_psram_bus_slave #(.LATENCY_CYCLES(LAT), .MEM_AW(10)) DUT (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .clock_in(host_ck),
        .clock_complement_in(~host_ck),
        .chip_select_n_in(host_cs_n),
        .reset_n_in(reset_n_in),
        .dq_in(dq_oe_n_out ? host_dq : dq_out),
        .read_write_strobe_in(read_write_strobe_oe_n_out ? host_strobe : read_write_strobe_out),
        .refresh_pending_in(refresh_pending_in),
        .wrap_group_sel_in(wrap_group_sel_in),
        .dq_out(dq_out),
        .dq_oe_n_out(dq_oe_n_out),
        .read_write_strobe_out(read_write_strobe_out),
        .read_write_strobe_oe_n_out(read_write_strobe_oe_n_out),
        .busy_out(busy_out)
    );

    task automatic stop_test();
        $display("Checks made %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_idle();
        check("idle flags", 16'h0003, {13'h0, busy_out, dq_oe_n_out, read_write_strobe_oe_n_out});
    endtask

    // One whole frame; memory reads are compared against the bench's copy of the array, register reads against zero.
    task automatic burst(input logic rd, input logic reg_sp, input logic lin,
                         input logic [31:0] start, input int n, input logic refr,
                         input logic [31:0] wmask, input logic keep_hi);
        logic [47:0] ca;
        logic [31:0] a;
        logic [15:0] w;
        ca = {rd, reg_sp, lin, start[31:3], 13'h0, start[2:0]};
        refresh_pending_in = refr;
        host.select();
        for (int i = 0; i < 6; i++) begin
            host.edge_byte(ca[47 - 8 * i -: 8], 1'b0, 2'h1);
            if (i == 2) begin
                check("flag strobe", {13'h0, 1'b1, refr, 1'b0}, {13'h0, busy_out, read_write_strobe_out, read_write_strobe_oe_n_out});
            end
        end
        // A released-line edge toggles at once, so keep the half period after the last byte.
        host.wait_ref(host.half / 2);
        repeat ((refr ? 4 : 2) * LAT) host.edge_byte(8'h00, 1'b0, 2'h0);
        for (int k = 0; k < n; k++) begin
            a = lin ? ((start + k) & 32'h00ff_ffff) : ((start & ~wmask) | ((start + k) & wmask));
            if (rd) begin
                w = reg_sp ? 16'h0000 : shadow[a[9:0]];
                host.edge_byte(8'h00, 1'b0, 2'h0);
                check("read high byte", {w[15:8], 8'h10}, {dq_out, 3'h0, read_write_strobe_out, 3'h0, dq_oe_n_out});
                host.edge_byte(8'h00, 1'b0, 2'h0);
                check("read low byte", {w[7:0], 8'h00}, {dq_out, 3'h0, read_write_strobe_out, 3'h0, dq_oe_n_out});
            end else begin
                w = {a[7:0] ^ 8'h3c, a[7:0] + 8'h11};
                host.edge_byte(w[15:8], keep_hi && k == 0, 2'h2);
                host.edge_byte(w[7:0], 1'b0, 2'h2);
                if (!reg_sp) begin
                    if (!(keep_hi && k == 0)) begin
                        shadow[a[9:0]][15:8] = w[15:8];
                    end
                    shadow[a[9:0]][7:0] = w[7:0];
                end
            end
        end
        host.deselect();
        check_idle();
    endtask

    // The reset pin lands in the command phase, while the strobe is driven.
    task automatic pin_reset();
        host.select();
        for (int i = 0; i < 4; i++) begin
            host.edge_byte(8'ha0, 1'b0, 2'h1);
        end
        reset_n_in = 1'b0;
        host.wait_ref(6);
        check_idle();
        reset_n_in = 1'b1;
        host.deselect();
        burst(1'b1, 1'b0, 1'b1, 32'h0000_0001, 2, 1'b0, 32'h0, 1'b0);
    endtask

    initial begin
        repeat (2) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        sys_rst_in = 1'b0;
        repeat (4) @(negedge ref_clk_in);
        burst(1'b0, 1'b0, 1'b1, 32'h0, 70, 1'b0, 32'h0, 1'b0);
        for (int s = 0; s < 4; s++) begin
            wrap_group_sel_in = s[1:0];
            burst(1'b1, 1'b0, 1'b0, 32'h2d, 8 << s, 1'b0, (32'h8 << s) - 32'h1, 1'b0);
        end
        burst(1'b1, 1'b0, 1'b1, 32'he, 20, 1'b1, 32'h0, 1'b0);
        burst(1'b0, 1'b0, 1'b1, 32'h3, 1, 1'b0, 32'h0, 1'b1);
        burst(1'b1, 1'b0, 1'b1, 32'h2, 3, 1'b0, 32'h0, 1'b0);
        burst(1'b0, 1'b0, 1'b1, 32'h00ff_ffff, 2, 1'b0, 32'h0, 1'b0);
        burst(1'b1, 1'b0, 1'b1, 32'h00ff_ffff, 2, 1'b0, 32'h0, 1'b0);
        burst(1'b0, 1'b1, 1'b1, 32'h5, 1, 1'b0, 32'h0, 1'b0);
        burst(1'b1, 1'b0, 1'b1, 32'h5, 1, 1'b0, 32'h0, 1'b0);
        burst(1'b1, 1'b1, 1'b1, 32'h5, 2, 1'b0, 32'h0, 1'b0);
        pin_reset();
        stop_test();
    end

    initial begin
        repeat (60000) @(posedge ref_clk_in);
        miscompares++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        stop_test();
    end
endmodule // ddr_psram_bus_slave_tb_top
